//--- adc_link_assertions.sv
// Concurrent checks on the serial link between converter end and controller end
`timescale 1ns/100ps
`default_nettype none
module adc_link_assertions (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic select_shutdown_n,
    input wire logic shift_clk,
    input wire logic din_o,
    input wire logic din_oe_n,
    input wire logic dout_o,
    input wire logic dout_oe_n,
    input wire logic fixed_variant
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Allows for the device's select synchronizer lag
    a_shutdown_release:
        assert property ($rose(select_shutdown_n) |-> ##[0:4] dout_oe_n)
        else $error("data output still driven after select rose");
    a_idle_quiet:
        assert property (select_shutdown_n [*5] |-> dout_oe_n && !shift_clk)
        else $error("link not idle while deselected");
    a_dout_on_fall:
        assert property (!select_shutdown_n && $past(!dout_oe_n) && !dout_oe_n
                         && $changed(dout_o) |-> !shift_clk)
        else $error("device changed data while shift clock high");
    a_din_on_fall:
        assert property (!din_oe_n && $changed(din_o) |-> !shift_clk)
        else $error("master changed data while shift clock high");
    a_no_contention:
        assert property (!(!din_oe_n && !dout_oe_n))
        else $error("both ends drive the data line");
    a_turn_released:
        assert property ($fell(dout_oe_n) |-> $past(din_oe_n) && !dout_o)
        else $error("device took the line before release or not low");
    a_wake_quiet:
        assert property ($fell(select_shutdown_n) |-> !shift_clk [*8])
        else $error("shift clock ran within the wake-up time");
    a_fixed_no_din:
        assert property (fixed_variant && !select_shutdown_n |-> din_oe_n)
        else $error("master drove data in the fixed-input variant");
endmodule
`default_nettype wire

//--- adc_link_if.sv
// Serial link between the converter end and the controller end
`timescale 1ns/100ps
`default_nettype none
interface adc_link_if;
    logic select_shutdown_n;
    logic shift_clk;
    logic din_o;
    logic din_oe_n;
    logic dout_o;
    logic dout_oe_n;
    logic fixed_variant;
    // Shared wire when the data pins are tied: driven end wins, else pulled high
    wire  data_line = !dout_oe_n ? dout_o : (!din_oe_n ? din_o : 1'b1);

    modport device (
        input  select_shutdown_n,
        input  shift_clk,
        input  data_line,
        input  fixed_variant,
        output dout_o,
        output dout_oe_n
    );
    modport master (
        output select_shutdown_n,
        output shift_clk,
        output din_o,
        output din_oe_n,
        output fixed_variant,
        input  data_line
    );
endinterface
`default_nettype wire

//--- adc_port_device.sv
// Converter end: serial port sequencing and conversion of a sampled code
`timescale 1ns/100ps
`default_nettype none
module adc_port_device
    import adc_port_pkg::*;
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    adc_link_if.device                link,
    input  wire logic [RESULT_W-1:0]  analog_input_a,
    input  wire logic [RESULT_W-1:0]  analog_input_b,
    output logic                      active_ff,
    output logic [RESULT_W-1:0]       result_ff
);
    import adc_port_pkg::*;

    logic [2:0]          cs_sync_ff;
    logic [2:0]          clk_sync_ff;
    logic [1:0]          dat_sync_ff;
    logic                cs_n;
    logic                rise;
    logic                fall;
    logic                cs_fall;
    dev_state_t          state_ff;
    logic [CFG_W-1:0]    cfg_ff;
    logic [1:0]          cnt_ff;
    logic [2:0]          bit_ff;
    logic                dout_ff;
    logic                oe_n_ff;
    logic [RESULT_W-1:0] nxt_result;

    // Select, clock and data pins pass two flops before use (fixed_variant is used unsynchronized); third stage only for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs_sync_ff  <= 3'h7;
            clk_sync_ff <= 3'h0;
            dat_sync_ff <= 2'h0;
        end else begin
            cs_sync_ff  <= {cs_sync_ff[1:0], link.select_shutdown_n};
            clk_sync_ff <= {clk_sync_ff[1:0], link.shift_clk};
            dat_sync_ff <= {dat_sync_ff[0], link.data_line};
        end
    end
    assign cs_n    = cs_sync_ff[1];
    assign rise    = clk_sync_ff[1] & ~clk_sync_ff[2];
    assign fall    = ~clk_sync_ff[1] & clk_sync_ff[2];
    assign cs_fall = ~cs_sync_ff[1] & cs_sync_ff[2];

    // Straight-binary code; differential difference floors at zero
    always_comb begin
        nxt_result = RESULT_RST;
        if (cfg_ff[CFG_SGL_POS]) begin
            nxt_result = cfg_ff[CFG_ODD_POS] ? analog_input_b : analog_input_a;
        end else if (!cfg_ff[CFG_ODD_POS]) begin
            if (analog_input_a > analog_input_b) begin
                nxt_result = analog_input_a - analog_input_b;
            end
        end else if (analog_input_b > analog_input_a) begin
            nxt_result = analog_input_b - analog_input_a;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_ff <= 1'b0;
        end else begin
            active_ff <= ~cs_n;
        end
    end

    // Sequencer; select high returns the state to idle and releases the output; config, counters and result_ff keep their values
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff  <= DEV_IDLE;
            cfg_ff    <= 3'h0;
            cnt_ff    <= 2'h0;
            bit_ff    <= 3'h0;
            dout_ff   <= 1'b0;
            oe_n_ff   <= 1'b1;
            result_ff <= RESULT_RST;
        end else if (cs_n) begin
            state_ff <= DEV_IDLE;
            oe_n_ff  <= 1'b1;
            dout_ff  <= 1'b0;
        end else begin
            unique case (state_ff)
                DEV_IDLE: begin
                    if (cs_fall) begin
                        state_ff <= link.fixed_variant ? DEV_NULL : DEV_SEEK;
                        cfg_ff   <= 3'h0;
                        cnt_ff   <= 2'h0;
                    end
                end
                DEV_SEEK: begin
                    if (rise && dat_sync_ff[1]) begin
                        state_ff <= DEV_CFG;
                    end
                end
                DEV_CFG: begin
                    if (rise && cnt_ff != 2'd3) begin
                        cfg_ff <= {cfg_ff[1:0], dat_sync_ff[1]};
                        cnt_ff <= cnt_ff + 2'd1;
                    end else if (fall && cnt_ff == 2'd3) begin
                        // 4th fall after start: take the line, null bit
                        oe_n_ff   <= 1'b0;
                        dout_ff   <= 1'b0;
                        result_ff <= nxt_result;
                        state_ff  <= DEV_MSB;
                        bit_ff    <= 3'd7;
                    end
                end
                DEV_NULL: begin
                    // Fixed variant: first clock pulse enables output as null bit
                    if (fall) begin
                        oe_n_ff   <= 1'b0;
                        dout_ff   <= 1'b0;
                        cfg_ff    <= 3'h0;
                        result_ff <= (analog_input_a > analog_input_b) ?
                                     analog_input_a - analog_input_b : RESULT_RST;
                        state_ff  <= DEV_MSB;
                        bit_ff    <= 3'd7;
                    end
                end
                DEV_MSB: begin
                    if (fall) begin
                        dout_ff <= result_ff[bit_ff];
                        if (bit_ff == 3'd0) begin
                            // Order bit one ends with zeros; LSB bit 0 already sent
                            state_ff <= cfg_ff[CFG_ORDER_POS] ? DEV_ZERO : DEV_LSB;
                            bit_ff   <= 3'd1;
                        end else begin
                            bit_ff <= bit_ff - 3'd1;
                        end
                    end
                end
                DEV_LSB: begin
                    if (fall) begin
                        dout_ff <= result_ff[bit_ff];
                        if (bit_ff == 3'd7) begin
                            state_ff <= DEV_ZERO;
                        end
                        bit_ff <= bit_ff + 3'd1;
                    end
                end
                DEV_ZERO: begin
                    if (fall) begin
                        dout_ff <= 1'b0;
                    end
                end
                default: begin
                    state_ff <= DEV_IDLE;
                end
            endcase
        end
    end

    assign link.dout_o    = dout_ff;
    assign link.dout_oe_n = oe_n_ff;
endmodule
`default_nettype wire

//--- adc_port_master.sv
// Controller end: APB-programmed master that runs one conversion exchange
`timescale 1ns/100ps
`default_nettype none
module adc_port_master
    import adc_port_pkg::*;
#(
    parameter int WAKE_CYC = WAKEUP_CYC,
    parameter int HALF_CYC = HALF_PERIOD_CYC
)(
    input  wire logic        pclk,
    input  wire logic        presetn,
    adc_link_if.master       link,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);
    import adc_port_pkg::*;
    localparam int TOTAL_BITS = 1 + CFG_W + 1 + 2 * RESULT_W;

    initial begin
        if (WAKE_CYC < 1 || HALF_CYC < 4) $error("bad timing parameters");
    end

    mst_state_t   state_ff;
    logic [3:0]   cfg_ff;
    logic         busy_ff;
    logic         done_ff;
    logic [15:0]  shreg_ff;
    logic [31:0]  tmr_ff;
    logic [4:0]   nbit_ff;
    logic [1:0]   dat_sync_ff;
    logic [31:0]  rd_ff;
    logic         rdy_ff;
    logic         go;
    logic [4:0]   tx_bits;
    logic [4:0]   null_bit;

    // Offsets: 0 control (w: bit0 go, bits3:1 config, bit4 fixed), 4 status, 8 data
    assign go      = psel && penable && pwrite && paddr == 12'h000 && pwdata[0] && !busy_ff;
    assign tx_bits = 5'(1 + CFG_W);
    // Clock index whose rise sees the null bit: second clock (fixed) or after config (mux)
    assign null_bit = cfg_ff[3] ? 5'd1 : 5'(1 + CFG_W);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdy_ff <= 1'b0;
            rd_ff  <= 32'h0;
        end else begin
            rdy_ff <= psel && !penable;
            if (psel && !penable && !pwrite) begin
                unique case (paddr)
                    12'h000: rd_ff <= {27'h0, cfg_ff, 1'b0};
                    12'h004: rd_ff <= {30'h0, done_ff, busy_ff};
                    12'h008: rd_ff <= {16'h0, shreg_ff};
                    default: rd_ff <= 32'h0;
                endcase
            end
        end
    end
    assign pready  = rdy_ff;
    assign prdata  = rd_ff;
    assign pslverr = 1'b0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dat_sync_ff <= 2'h0;
        end else begin
            dat_sync_ff <= {dat_sync_ff[0], link.data_line};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff               <= MST_IDLE;
            cfg_ff                 <= 4'h0;
            busy_ff                <= 1'b0;
            done_ff                <= 1'b0;
            shreg_ff               <= 16'h0;
            tmr_ff                 <= 32'h0;
            nbit_ff                <= 5'h0;
            link.select_shutdown_n <= 1'b1;
            link.shift_clk         <= 1'b0;
            link.din_o             <= 1'b0;
            link.din_oe_n          <= 1'b1;
            link.fixed_variant     <= 1'b0;
        end else begin
            unique case (state_ff)
                MST_IDLE: begin
                    if (go) begin
                        cfg_ff                 <= pwdata[4:1];
                        link.fixed_variant     <= pwdata[4];
                        busy_ff                <= 1'b1;
                        done_ff                <= 1'b0;
                        link.select_shutdown_n <= 1'b0;
                        tmr_ff                 <= 32'(WAKE_CYC);
                        nbit_ff                <= 5'h0;
                        state_ff               <= MST_WAKE;
                    end
                end
                MST_WAKE: begin
                    // Whole wake-up spent before the first clock: simplest safe choice
                    if (tmr_ff == 32'h0) begin
                        state_ff <= MST_LOW;
                        tmr_ff   <= 32'(HALF_CYC);
                        if (!cfg_ff[3]) begin
                            link.din_oe_n <= 1'b0;
                            link.din_o    <= 1'b1;
                        end
                    end else begin
                        tmr_ff <= tmr_ff - 32'h1;
                    end
                end
                MST_LOW: begin
                    if (tmr_ff == 32'h0) begin
                        link.shift_clk <= 1'b1;
                        tmr_ff         <= 32'(HALF_CYC);
                        state_ff       <= MST_HIGH;
                        // Sample just before the rise so the device's falling data settled
                        // Keep exactly the 16 bits that follow the null bit
                        if (nbit_ff > null_bit && nbit_ff <= null_bit + 5'd16) begin
                            shreg_ff <= {shreg_ff[14:0], dat_sync_ff[1]};
                        end
                    end else begin
                        tmr_ff <= tmr_ff - 32'h1;
                    end
                end
                MST_HIGH: begin
                    if (tmr_ff == 32'h0) begin
                        link.shift_clk <= 1'b0;
                        nbit_ff        <= nbit_ff + 5'd1;
                        tmr_ff         <= 32'(HALF_CYC);
                        state_ff       <= (nbit_ff == 5'(TOTAL_BITS)) ? MST_DONE : MST_LOW;
                        // Launch next config bit on the fall; release on the 4th fall
                        if (!cfg_ff[3] && nbit_ff + 5'd1 < tx_bits) begin
                            link.din_o <= cfg_ff[2 - 32'(nbit_ff)];
                        end else begin
                            link.din_oe_n <= 1'b1;
                        end
                    end else begin
                        tmr_ff <= tmr_ff - 32'h1;
                    end
                end
                MST_DONE: begin
                    link.select_shutdown_n <= 1'b1;
                    busy_ff                <= 1'b0;
                    done_ff                <= 1'b1;
                    state_ff               <= MST_IDLE;
                end
                default: begin
                    state_ff <= MST_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

//--- adc_port_pkg.sv
// Shared constants and types for the sampling converter serial port and its master
// Functional notes
// - Select high means shutdown; low means active
// - Master allows 10 us wake-up after select
// - Clock at 100kHz or slower needs no delay
// - Launch on falling clock, sample on rising
// - Mux variant: config in, then result out
// - Select falling starts transfer; seek start bit
// - First one sampled is start; zeros discarded
// - Three config bits follow start, trigger conversion
// - Input ignored after config until reselect
// - One null bit precedes result on mux variant
// - Master raises select; device resets its port
// - Fixed variant: first clock enables output, null
// - Fixed variant: MSB first, then LSB first
// - Single-ended: polarity picks channel against ground
// - Differential: polarity picks subtraction direction
// - Bit order one: MSB first, then zeros
// - Bit order zero: MSB first then LSB first
// - After result, extra clocks give zeros forever
// - Result is unsigned straight binary
// - Eight-bit successive approximation result
// - Device drives line on 4th fall after start
package adc_port_pkg;
    localparam int          RESULT_W       = 8;
    localparam int          CFG_W          = 3;
    localparam int          CFG_SGL_POS    = 2;
    localparam int          CFG_ODD_POS    = 1;
    localparam int          CFG_ORDER_POS  = 0;
    localparam int          CLK_MHZ        = 100;
    localparam int          WAKEUP_US      = 10;
    localparam int          WAKEUP_CYC     = WAKEUP_US * CLK_MHZ;
    localparam int          HALF_PERIOD_CYC = 50;
    localparam logic [7:0]  RESULT_RST     = 8'h00;

    typedef enum logic [2:0] {
        DEV_IDLE   = 3'b000,
        DEV_SEEK   = 3'b001,
        DEV_CFG    = 3'b010,
        DEV_NULL   = 3'b011,
        DEV_MSB    = 3'b100,
        DEV_LSB    = 3'b101,
        DEV_ZERO   = 3'b110
    } dev_state_t;

    typedef enum logic [2:0] {
        MST_IDLE   = 3'b000,
        MST_WAKE   = 3'b001,
        MST_LOW    = 3'b010,
        MST_HIGH   = 3'b011,
        MST_DONE   = 3'b100
    } mst_state_t;
endpackage

//--- adc_serial_port_mux_config_tb_top.sv
// Testbench: APB-driven exchanges across both ends of the converter link
`timescale 1ns/100ps
`default_nettype none
module adc_serial_port_mux_config_tb_top;
    import adc_port_pkg::*;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  ana_a;
    logic [7:0]  ana_b;
    logic        active_ff;
    logic [7:0]  result_ff;
    logic [31:0] rd;
    logic [20:0] cases [6];
    int          n_mismatch;
    int          compares;
    int          cycles;

    adc_link_if link ();
    adc_port_device adc_port_device_i (.pclk(pclk), .presetn(presetn), .link(link),
        .analog_input_a(ana_a), .analog_input_b(ana_b), .active_ff(active_ff),
        .result_ff(result_ff));
    // Short wake and half period keep each frame near 408 cycles
    adc_port_master #(.WAKE_CYC(10), .HALF_CYC(8)) adc_port_master_i (.pclk(pclk),
        .presetn(presetn), .link(link), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    adc_link_assertions adc_link_assertions_i (.pclk(pclk), .presetn(presetn),
        .select_shutdown_n(link.select_shutdown_n), .shift_clk(link.shift_clk),
        .din_o(link.din_o), .din_oe_n(link.din_oe_n), .dout_o(link.dout_o),
        .dout_oe_n(link.dout_oe_n), .fixed_variant(link.fixed_variant));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic tally_and_finish;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                            output logic [31:0] q);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Expected 16 bits after null: MSB first, then bits 1..7 back (bit 0 shared) or zeros for mux order one, then a zero
    function automatic logic [15:0] expect_word(input logic [4:0] c, input logic [7:0] a,
                                                input logic [7:0] b);
        logic [7:0] r;
        logic [7:0] v;
        if (c[4] || (!c[3] && !c[2])) r = (a > b) ? a - b : 8'h00;
        else if (c[3]) r = c[2] ? b : a;
        else r = (b > a) ? b - a : 8'h00;
        v = 8'h00;
        for (int k = 1; k < 8; k++) v[k] = r[8-k];
        if (c[1] && !c[4]) v = 8'h00;
        return {r, v};
    endfunction

    task automatic wait_done;
        int n;
        n = 0;
        rd = 32'h0;
        while (rd[1:0] !== 2'b10 && n < 300) begin
            apb_xfer(1'b0, 12'h004, 32'h0, rd);
            n++;
        end
    endtask

    initial begin
        logic [4:0]  c;
        logic [7:0]  a;
        logic [7:0]  b;
        logic [15:0] e;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {ana_a, ana_b} = 16'h5a23;
        n_mismatch = 0;
        compares = 0;
        cycles = 0;
        // Control word: bit1 order, bit2 polarity, bit3 single-ended, bit4 fixed
        cases = '{{5'h0b, 16'h5a23}, {5'h0d, 16'h5a23}, {5'h01, 16'h5a23},
                  {5'h05, 16'h5a23}, {5'h13, 16'h5a23}, {5'h09, 16'hff01}};
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb_xfer(1'b0, 12'h00c, 32'h0, rd);
        chk(rd, 32'h0, "unmapped read");
        apb_xfer(1'b1, 12'h000, 32'h0000_0001, rd);
        repeat (100) @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        @(negedge pclk);
        chk({30'h0, link.select_shutdown_n, link.dout_oe_n}, 32'h3, "reset mid-frame");
        @(posedge pclk);
        presetn <= 1'b1;
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            {c, a, b} = cases[i];
            e = expect_word(c, a, b);
            ana_a <= a;
            ana_b <= b;
            apb_xfer(1'b1, 12'h000, {27'h0, c}, rd);
            apb_xfer(1'b0, 12'h000, 32'h0, rd);
            chk(rd, {27'h0, c & 5'h1e}, "ctrl readback");
            apb_xfer(1'b1, 12'h000, {27'h0, c ^ 5'h0e}, rd);
            wait_done();
            chk(rd, 32'h2, "status done");
            apb_xfer(1'b0, 12'h008, 32'h0, rd);
            chk(rd, {16'h0, e}, "sampled bits");
            chk({24'h0, result_ff}, {24'h0, e[15:8]}, "result");
            chk({31'h0, active_ff}, 32'h0, "shutdown after frame");
            $display("test %0d done", i);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
